// File: ifb_pkg.sv
// Shared constants and types for the interrupt flag and enable bank.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package ifb_pkg;

  // Register byte offsets
  localparam logic [6:0] OFS_FLAGS0 = 7'h00;
  localparam logic [6:0] OFS_FLAGS1 = 7'h04;
  localparam logic [6:0] OFS_FLAGS2 = 7'h08;
  localparam logic [6:0] OFS_ENABLES0 = 7'h0C;
  localparam logic [6:0] OFS_ENABLES1 = 7'h10;
  localparam logic [6:0] OFS_ENABLES2 = 7'h14;
  localparam logic [6:0] OFS_PRIO_BASE = 7'h20;
  localparam logic [6:0] OFS_PRIO_LAST = 7'h4C;
  localparam logic [6:0] OFS_STATUS = 7'h50;

  // Implemented bit masks; all other bits read zero
  localparam logic [15:0] MASK_BANK0 = 16'h7FEF;
  localparam logic [15:0] MASK_BANK1 = 16'hE87F;
  localparam logic [15:0] MASK_BANK2 = 16'h07E1;
  localparam logic [15:0] MASK_PRIO = 16'h7777;

  // Field positions in bank 0
  localparam int BIT_EXT_PIN0 = 0;
  localparam int BIT_CAPTURE1 = 1;
  localparam int BIT_COMPARE1 = 2;
  localparam int BIT_TIMER1 = 3;
  localparam int BIT_COMPARE2 = 5;
  localparam int BIT_TIMER2 = 6;
  localparam int BIT_TIMER3 = 7;
  localparam int BIT_SPI_EVENT = 8;
  localparam int BIT_UART_RX = 9;
  localparam int BIT_UART_TX = 10;
  localparam int BIT_ADC_COMPLETE = 11;
  localparam int BIT_NONVOLATILE = 12;
  localparam int BIT_I2C_SLAVE = 13;
  localparam int BIT_I2C_MASTER = 14;
  // Field positions in bank 1
  localparam int BIT_EXT_PIN1 = 0;
  localparam int BIT_EXT_PIN2 = 1;
  localparam int BIT_PWM_SPECIAL = 2;
  localparam int BIT_PWM_GEN1 = 3;
  localparam int BIT_PWM_GEN4 = 6;
  localparam int BIT_CHANGE_NOTIFY = 11;
  localparam int BIT_COMPARATOR1 = 13;
  localparam int BIT_COMPARATOR3 = 15;
  // Field positions in bank 2
  localparam int BIT_COMPARATOR4 = 0;
  localparam int BIT_ADC_PAIR0 = 5;
  localparam int BIT_ADC_PAIR5 = 10;

  // Values after reset
  localparam logic [15:0] RESET_BANK = 16'h0000;
  localparam logic [15:0] RESET_PRIO = 16'h4444;
  localparam logic [2:0] PRIO_OFF = 3'h0;

  // Sizes
  localparam int NUM_SOURCES = 48;
  localparam int NUM_PRIO_REGS = 12;

  // Avalon response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECODE_ERR = 2'h3;

  // One event pulse word per flag bank
  typedef struct packed {
    logic [15:0] bank2;
    logic [15:0] bank1;
    logic [15:0] bank0;
  } ifb_events_t;

  // Requests presented to the core
  typedef struct packed {
    logic [2:0] level;
    logic [NUM_SOURCES-1:0] pending;
  } ifb_request_t;

endpackage : ifb_pkg

// File: ifb_bank.sv
// Interrupt request flag, enable and priority bank with Avalon-MM access.
// Assumes event pulses come from logic on ref_clk and need no synchroniser.
//
// Overview of operation
// [RULE1] Comparator 3,2,1 flags at bank1 bits 15-13
// [RULE2] Change notification flag at bank1 bit 11
// [RULE3] PWM generator 4-1 flags at bank1 bits 6-3
// [RULE4] PWM special match flag at bank1 bit 2
// [RULE5] External pin 2,1 flags at bank1 bits 1-0
// [RULE6] ADC pair 5-0 flags at bank2 bits 10-5
// [RULE7] Comparator 4 flag at bank2 bit 0
// [RULE8] Compare1, capture1, pin0 flags at bank0 bits 2-0
// [RULE9] Bank2 bits 15-11 and 4-1 read zero
// [RULE10] Bank1 bits 12 and 10-7 read zero
// [RULE11] Flags show raised requests; software reads, writes
// [RULE12] Reset clears every flag and enable bit
// [RULE13] Enable one passes request, zero blocks it
// [RULE14] Enables0 bits 14-8: I2C, memory, ADC, UART, SPI
// [RULE15] Enables0 bits 7-5, 3-0 timers, compares, capture
// [RULE16] Enables0 bit 15 reads zero
// [RULE17] Three-bit priority per source, zero disables
// [RULE18] Event sets flag next cycle; request needs enable
// [RULE19] Software clears with zero; hardware set wins
//
// The placing of the registers and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps

module ifb_bank (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic [1:0] avs_response,
  output logic avs_waitrequest,
  // Peripheral event pulses
  input wire ifb_pkg::ifb_events_t events,
  // Requests to the core
  output ifb_pkg::ifb_request_t request
);

  logic [15:0] flags0;
  logic [15:0] flags1;
  logic [15:0] flags2;
  logic [15:0] enables0;
  logic [15:0] enables1;
  logic [15:0] enables2;
  logic [15:0] prio_mem [0:ifb_pkg::NUM_PRIO_REGS-1];

  // Bus decode
  wire bus_req = avs_read | avs_write;
  wire accept = bus_req & avs_waitrequest;
  wire wr_take = avs_write & ~avs_waitrequest;
  wire [15:0] lane_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  wire [15:0] wdata = avs_writedata[15:0];
  wire sel_f0 = avs_address == ifb_pkg::OFS_FLAGS0;
  wire sel_f1 = avs_address == ifb_pkg::OFS_FLAGS1;
  wire sel_f2 = avs_address == ifb_pkg::OFS_FLAGS2;
  wire sel_e0 = avs_address == ifb_pkg::OFS_ENABLES0;
  wire sel_e1 = avs_address == ifb_pkg::OFS_ENABLES1;
  wire sel_e2 = avs_address == ifb_pkg::OFS_ENABLES2;
  wire sel_st = avs_address == ifb_pkg::OFS_STATUS;
  wire sel_pr = avs_address >= ifb_pkg::OFS_PRIO_BASE && avs_address <= ifb_pkg::OFS_PRIO_LAST
                && avs_address[1:0] == 2'h0;
  wire [6:0] prio_ofs = avs_address - ifb_pkg::OFS_PRIO_BASE;
  wire [3:0] prio_idx = prio_ofs[5:2];
  wire mapped = sel_f0 | sel_f1 | sel_f2 | sel_e0 | sel_e1 | sel_e2 | sel_pr | sel_st;

  // Event words limited to implemented positions
  wire [15:0] ev0 = events.bank0 & ifb_pkg::MASK_BANK0; // [RULE8]
  wire [15:0] ev1 = events.bank1 & ifb_pkg::MASK_BANK1; // [RULE1] [RULE2] [RULE3] [RULE4] [RULE5]
  wire [15:0] ev2 = events.bank2 & ifb_pkg::MASK_BANK2; // [RULE6] [RULE7]

  // Byte-lane merge of a software write into a register
  function automatic logic [15:0] merge(input logic [15:0] cur, input logic [15:0] wd,
                                        input logic [15:0] lanes, input logic [15:0] mask);
    merge = ((cur & ~lanes) | (wd & lanes)) & mask;
  endfunction : merge

  // A set from hardware is ORed after the write, so it beats a clear
  wire [15:0] wr_f0 = (wr_take & sel_f0) ? merge(flags0, wdata, lane_mask, ifb_pkg::MASK_BANK0) : flags0;
  wire [15:0] wr_f1 = (wr_take & sel_f1) ? merge(flags1, wdata, lane_mask, ifb_pkg::MASK_BANK1) : flags1;
  wire [15:0] wr_f2 = (wr_take & sel_f2) ? merge(flags2, wdata, lane_mask, ifb_pkg::MASK_BANK2) : flags2;
  wire [15:0] next_flags0 = wr_f0 | ev0; // [RULE11] [RULE18] [RULE19]
  wire [15:0] next_flags1 = wr_f1 | ev1; // [RULE11] [RULE18] [RULE19]
  wire [15:0] next_flags2 = wr_f2 | ev2; // [RULE11] [RULE18] [RULE19]

  wire [15:0] next_enables0 = (wr_take & sel_e0) ?
                              merge(enables0, wdata, lane_mask, ifb_pkg::MASK_BANK0) : enables0; // [RULE14] [RULE15]
  wire [15:0] next_enables1 = (wr_take & sel_e1) ?
                              merge(enables1, wdata, lane_mask, ifb_pkg::MASK_BANK1) : enables1;
  wire [15:0] next_enables2 = (wr_take & sel_e2) ?
                              merge(enables2, wdata, lane_mask, ifb_pkg::MASK_BANK2) : enables2;

  // Source vector and enable vector, 16 slots per bank
  wire [47:0] flag_vec = {flags2, flags1, flags0};
  wire [47:0] en_vec = {enables2, enables1, enables0};

  // Pending requests and highest active level
  logic [47:0] next_pending;
  logic [2:0] next_level;
  always_comb begin
    logic [2:0] pl;
    pl = ifb_pkg::PRIO_OFF;
    next_pending = '0;
    next_level = ifb_pkg::PRIO_OFF;
    for (int i = 0; i < ifb_pkg::NUM_SOURCES; i++) begin
      pl = prio_mem[i / 4][(i % 4) * 4 +: 3];
      // Priority zero disables the source outright
      next_pending[i] = flag_vec[i] & en_vec[i] & (pl != ifb_pkg::PRIO_OFF); // [RULE13] [RULE17] [RULE18]
      if (next_pending[i] && pl > next_level) begin
        next_level = pl;
      end
    end
  end

  // Read mux; unimplemented bits are zero because the stores are masked
  logic [15:0] rd_word;
  always_comb begin
    rd_word = 16'h0000;
    if (sel_f0) begin
      rd_word = flags0 & ifb_pkg::MASK_BANK0;
    end else if (sel_f1) begin
      rd_word = flags1 & ifb_pkg::MASK_BANK1; // [RULE10]
    end else if (sel_f2) begin
      rd_word = flags2 & ifb_pkg::MASK_BANK2; // [RULE9]
    end else if (sel_e0) begin
      rd_word = enables0 & ifb_pkg::MASK_BANK0; // [RULE16]
    end else if (sel_e1) begin
      rd_word = enables1 & ifb_pkg::MASK_BANK1;
    end else if (sel_e2) begin
      rd_word = enables2 & ifb_pkg::MASK_BANK2;
    end else if (sel_pr) begin
      rd_word = prio_mem[prio_idx] & ifb_pkg::MASK_PRIO;
    end else if (sel_st) begin
      rd_word = {13'h0000, request.level};
    end
  end

  // Bus handshake: one wait cycle, then a single ready cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      avs_response <= ifb_pkg::RESP_OKAY;
    end else begin
      avs_waitrequest <= ~accept;
      if (accept) begin
        avs_readdata <= avs_read ? {16'h0000, rd_word} : 32'h0000_0000;
        avs_response <= mapped ? ifb_pkg::RESP_OKAY : ifb_pkg::RESP_DECODE_ERR;
      end
    end
  end

  // Flags and enables
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flags0 <= ifb_pkg::RESET_BANK; // [RULE12]
      flags1 <= ifb_pkg::RESET_BANK; // [RULE12]
      flags2 <= ifb_pkg::RESET_BANK; // [RULE12]
      enables0 <= ifb_pkg::RESET_BANK; // [RULE12]
      enables1 <= ifb_pkg::RESET_BANK;
      enables2 <= ifb_pkg::RESET_BANK;
    end else begin
      flags0 <= next_flags0;
      flags1 <= next_flags1;
      flags2 <= next_flags2;
      enables0 <= next_enables0;
      enables1 <= next_enables1;
      enables2 <= next_enables2;
    end
  end

  // Priority settings
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      for (int r = 0; r < ifb_pkg::NUM_PRIO_REGS; r++) begin
        prio_mem[r] <= ifb_pkg::RESET_PRIO;
      end
    end else if (wr_take && sel_pr) begin
      prio_mem[prio_idx] <= merge(prio_mem[prio_idx], wdata, lane_mask, ifb_pkg::MASK_PRIO); // [RULE17]
    end
  end

  // Requests are registered, so they trail the flag by one cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      request <= '0;
    end else begin
      request.pending <= next_pending;
      request.level <= next_level;
    end
  end

endmodule : ifb_bank

// File: ifb_monitor.sv
// Checker for the flag and enable bank bus answers and request outputs.
// Assumes it is bound to ifb_bank and sees only that module's ports.
`timescale 1ns/1ps
module ifb_monitor (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic [6:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Events and requests
  input wire ifb_pkg::ifb_events_t events,
  input wire ifb_pkg::ifb_request_t request
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire rd_ack = avs_read && !avs_waitrequest;
  wire ev_any = |events;
  property p_ack; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_one; !avs_waitrequest |=> avs_waitrequest; endproperty
  property p_hold; avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata); endproperty
  property p_f1; rd_ack && avs_address == ifb_pkg::OFS_FLAGS1 |-> (avs_readdata & 32'hFFFF1780) == 32'h0; endproperty
  property p_f2; rd_ack && avs_address == ifb_pkg::OFS_FLAGS2 |-> (avs_readdata & 32'hFFFFF81E) == 32'h0; endproperty
  property p_e0; rd_ack && avs_address == ifb_pkg::OFS_ENABLES0 |-> (avs_readdata & 32'hFFFF8010) == 32'h0; endproperty
  // A request may only appear after an event or a register write
  property p_rise; $rose(|request.pending) |-> $past(ev_any, 2) || $past(avs_write) || $past(avs_write, 2); endproperty
  property p_lvl; (request.level == 3'h0) == (request.pending == '0); endproperty
  a_ack: assert property (p_ack) else $error("no answer one cycle after request");
  a_one: assert property (p_one) else $error("waitrequest low for more than one cycle");
  a_hold: assert property (p_hold) else $error("read data changed while idle");
  a_f1: assert property (p_f1) else $error("unimplemented flag bank 1 bit read as one");
  a_f2: assert property (p_f2) else $error("unimplemented flag bank 2 bit read as one");
  a_e0: assert property (p_e0) else $error("unimplemented enable bit read as one");
  a_rise: assert property (p_rise) else $error("request rose without cause");
  a_lvl: assert property (p_lvl) else $error("level disagrees with pending");
  c_rd: cover property (rd_ack);
  c_wr: cover property (avs_write && !avs_waitrequest);
  c_req: cover property (|request.pending);
endmodule : ifb_monitor

bind ifb_bank ifb_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .events(events), .request(request));

// File: ifb_event_src.sv
// Peripheral event source model: one-cycle pulses on ref_clk.
// Assumes the bench asks for one pulse at a time by bank*16+bit index.
`timescale 1ns/1ps
module ifb_event_src (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Bench control
  input wire logic fire,
  input wire logic [5:0] sel,
  // Pulses to the bank
  output ifb_pkg::ifb_events_t events
);
  always_ff @(posedge ref_clk) begin
    // Never a level, so a stuck flag cannot hide behind a held source
    events <= '0;
    if (rst_n && fire) begin
      events[sel] <= 1'b1;
    end
  end
endmodule : ifb_event_src

// File: ifb_bank_tb.sv
// Self-checking bench for the flag and enable bank.
// Assumes ifb_bank, ifb_event_src and the bound checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module ifb_bank_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] avs_address = 7'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [1:0] avs_response;
  logic avs_waitrequest;
  logic fire = 1'b0;
  logic [5:0] sel = 6'h00;
  logic [31:0] q;
  logic [1:0] r;
  int fails = 0;
  int samples_checked = 0;
  ifb_pkg::ifb_events_t events;
  ifb_pkg::ifb_request_t request;
  logic [6:0] adr [4] = '{ifb_pkg::OFS_FLAGS0, ifb_pkg::OFS_FLAGS1, ifb_pkg::OFS_FLAGS2, ifb_pkg::OFS_ENABLES0};
  logic [15:0] msk [4] = '{16'h7FEF, 16'hE87F, 16'h07E1, 16'h7FEF};
  logic [5:0] src [21] = '{6'h1F, 6'h1E, 6'h1D, 6'h1B, 6'h16, 6'h15, 6'h14, 6'h13, 6'h12, 6'h11, 6'h10,
    6'h2A, 6'h29, 6'h28, 6'h27, 6'h26, 6'h25, 6'h20, 6'h02, 6'h01, 6'h00};
  always #12.5 ref_clk = ~ref_clk;
  ifb_event_src src_m (.ref_clk(ref_clk), .rst_n(rst_n), .fire(fire), .sel(sel), .events(events));
  ifb_bank dut (.ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(4'h3), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_response(avs_response), .avs_waitrequest(avs_waitrequest), .events(events), .request(request));
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results
  task automatic acc(input logic [6:0] a, input logic w, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= ~w;
    avs_writedata <= {16'h0000, d};
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      results();
    end else begin
      q = avs_readdata;
      r = avs_response;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask : acc
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    acc(a, 1'b0, 16'h0000);
    `CHK(q, {16'h0000, e})
  endtask : rd
  task automatic pulse(input logic [5:0] s);
    @(posedge ref_clk);
    sel <= s;
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    @(posedge ref_clk);
  endtask : pulse
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(adr[i], 16'h0000);
      acc(adr[i], 1'b1, 16'hFFFF);
      rd(adr[i], msk[i]);
      acc(adr[i], 1'b1, 16'h0000);
      rd(adr[i], 16'h0000);
      `CHK(r, ifb_pkg::RESP_OKAY)
    end
    // Unmapped place reads zero with a decode error
    rd(7'h7C, 16'h0000);
    `CHK(r, ifb_pkg::RESP_DECODE_ERR)
    for (int i = 0; i < 21; i++) begin
      pulse(src[i]);
      rd(adr[src[i][5:4]], 16'h0001 << src[i][3:0]);
      acc(adr[src[i][5:4]], 1'b1, 16'h0000);
    end
    pulse(6'h2C);
    rd(ifb_pkg::OFS_FLAGS2, 16'h0000);
    pulse(6'h03);
    repeat (2) @(posedge ref_clk);
    `CHK(request, {3'h0, 48'h0})
    acc(ifb_pkg::OFS_ENABLES0, 1'b1, 16'h0008);
    repeat (2) @(posedge ref_clk);
    `CHK(request, {3'h4, 48'h8})
    acc(ifb_pkg::OFS_PRIO_BASE, 1'b1, 16'h0444);
    repeat (2) @(posedge ref_clk);
    `CHK(request, {3'h0, 48'h0})
    acc(ifb_pkg::OFS_PRIO_BASE, 1'b1, 16'h7444);
    repeat (2) @(posedge ref_clk);
    `CHK(request, {3'h7, 48'h8})
    rd(ifb_pkg::OFS_STATUS, 16'h0007);
    acc(ifb_pkg::OFS_FLAGS0, 1'b1, 16'h0000);
    repeat (2) @(posedge ref_clk);
    `CHK(request, {3'h0, 48'h0})
    // Event lands on the very edge of the clearing write
    fork
      acc(ifb_pkg::OFS_FLAGS0, 1'b1, 16'h0000);
      begin
        @(posedge ref_clk);
        sel <= 6'h00;
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
      end
    join
    rd(ifb_pkg::OFS_FLAGS0, 16'h0001);
    results();
  end
endmodule : ifb_bank_tb
